// ### tbd_decoder.v
// Purpose: Type B link command and APDU decoder for the tag
// Assumes: frames arrive CRC-checked, one byte per valid cycle
// Notes:   payload goes to memory or host through a FIFO
`default_nettype none
`include "tbd_map.vh"
module tbd_decoder #(
    parameter AW        = 15,
    parameter MEM_BYTES = 16'h2000,
    parameter MAX_LEN   = 8'hF0,
    parameter HOST_WAIT = `TBD_HOST_WAIT_US * `TBD_CLK_MHZ
) (
    // Clock and reset
    input  wire            clk_sys,
    input  wire            rst,
    // Frame input from block layer
    input  wire            rx_valid,
    input  wire [7:0]      rx_data,
    input  wire            rx_last,
    input  wire            rx_is_apdu,
    // Block control events
    input  wire            blk_chain,
    input  wire            blk_ack,
    input  wire            blk_nak,
    input  wire            blk_deselect,
    // Configuration
    input  wire [15:0]     read_only_region_setting,
    // Status out
    output reg             sw_valid,
    output reg  [7:0]      sw1,
    output reg  [7:0]      sw2,
    output reg  [2:0]      link_state,
    output reg             chain_active,
    output reg             resend_req,
    // Access request
    output reg             acc_start,
    output reg             acc_write,
    output reg             acc_tunnel,
    output reg  [AW-1:0]   acc_addr,
    output reg  [7:0]      acc_len,
    // Payload out
    output wire            pay_valid,
    input  wire            pay_ready,
    output wire [7:0]      pay_data,
    output wire            rx_ready,
    // Host answer in tunnel mode
    input  wire            host_done,
    input  wire            host_err
);
    // ==================================================
    // Link states
    localparam ST_IDLE   = 3'd0;
    localparam ST_READY  = 3'd1;
    localparam ST_ACTIVE = 3'd2;
    localparam ST_HALT   = 3'd3;
    // APDU parse phases
    localparam PH_CLA  = 3'd0;
    localparam PH_INS  = 3'd1;
    localparam PH_P1   = 3'd2;
    localparam PH_P2   = 3'd3;
    localparam PH_LC   = 3'd4;
    localparam PH_DATA = 3'd5;
    localparam PH_WAIT = 3'd6;
    localparam PH_SKIP = 3'd7;
    // Status words split into bytes for the answer phase
    localparam [15:0] SW_OK     = `TBD_SW_OK;
    localparam [15:0] SW_NOHOST = `TBD_SW_NOHOST;
    localparam [15:0] SW_HOSTER = `TBD_SW_HOSTERR;

    reg  [2:0]  phase;
    reg  [2:0]  lphase;
    reg  [7:0]  cla;
    reg  [7:0]  ins;
    reg  [7:0]  p1;
    reg  [7:0]  p2;
    reg  [7:0]  lc;
    reg  [7:0]  dcount;
    reg         has_lc;
    reg         link_cmd_req;
    reg  [19:0] wait_cnt;
    reg  [15:0] next_sw;
    wire        fifo_in_ready;
    wire        data_byte;
    wire [15:0] addr_full;
    wire [2:0]  mode;
    wire        tunnel;
    wire        is_rw;
    wire        is_wr;
    wire [15:0] end_addr;

    // ==================================================
    // Field decode
    assign addr_full = {1'b0, p1[6:0], p2};
    assign mode      = p1[`TBD_MODE_HI:`TBD_MODE_LO];
    assign tunnel    = (mode == `TBD_MODE_TUNNEL);
    assign is_wr     = (ins == `TBD_INS_WRITE);
    assign is_rw     = (ins == `TBD_INS_READ) || is_wr;
    assign end_addr  = {4'h0, p1[3:0], p2} + {8'h00, lc};
    assign data_byte = rx_valid && (phase == PH_DATA) && fifo_in_ready;
    assign rx_ready  = (phase != PH_DATA) || fifo_in_ready;

    // Byte payload, no structure assumed
    tbd_fifo #(
        .WIDTH (8),
        .DEPTH (8),
        .AW    (3)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .flush     (rx_valid && phase == PH_CLA),
        .in_valid  (rx_valid && phase == PH_DATA),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_data),
        .out_valid (pay_valid),
        .out_ready (pay_ready),
        .out_data  (pay_data)
    );

    // ==================================================
    // Status priority at end of header
    always @* begin
        next_sw = `TBD_SW_OK;
        if (cla != `TBD_CLA_OK) begin
            next_sw = `TBD_SW_CLA;
        end else if (ins == `TBD_INS_SELECT) begin
            next_sw = `TBD_SW_OK;
        end else if (!is_rw) begin
            next_sw = `TBD_SW_INS;
        end else if (p1[`TBD_P1_TOP]) begin
            next_sw = `TBD_SW_P1P2;
        end else if (mode != `TBD_MODE_RF && !tunnel) begin
            next_sw = `TBD_SW_P1P2;
        end else if (lc > MAX_LEN || (is_wr && !has_lc) || (is_wr && lc == 8'h00)) begin
            next_sw = `TBD_SW_LEN;
        end else if (!tunnel && end_addr > MEM_BYTES) begin
            next_sw = `TBD_SW_P1P2;
        end else if (!tunnel && is_wr &&
                     {4'h0, p1[3:0], p2} < read_only_region_setting) begin
            next_sw = `TBD_SW_RO;
        end
    end

    // ==================================================
    // Link-level state
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lphase       <= PH_CLA;
            link_state   <= ST_IDLE;
            link_cmd_req <= 1'b0;
        end else begin
            if (rx_valid && !rx_is_apdu) begin
                if (lphase == PH_CLA) begin
                    lphase <= PH_INS;
                    case (rx_data)
                        `TBD_CMD_REQ: begin
                            link_cmd_req <= 1'b1;
                        end
                        `TBD_CMD_ATTACH: begin
                            if (link_state == ST_READY) begin
                                link_state <= ST_ACTIVE;
                            end
                        end
                        `TBD_CMD_HALT: begin
                            link_state <= ST_HALT;
                        end
                        default: begin
                            link_state <= link_state;
                        end
                    endcase
                end else if (lphase == PH_INS && link_cmd_req) begin
                    lphase       <= PH_P1;
                    link_cmd_req <= 1'b0;
                end else if (lphase == PH_P1) begin
                    lphase <= PH_SKIP;
                    // Wake form in idle or halt, request form idle only
                    if (rx_data[`TBD_PARAM_WAKE]) begin
                        if (link_state == ST_IDLE || link_state == ST_HALT) begin
                            link_state <= ST_READY;
                        end
                    end else if (link_state == ST_IDLE) begin
                        link_state <= ST_READY;
                    end
                end
                if (rx_last) begin
                    lphase       <= PH_CLA;
                    link_cmd_req <= 1'b0;
                end
            end
            if (blk_deselect) begin
                link_state <= ST_HALT;
            end
        end
    end

    // ==================================================
    // Block control flags
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chain_active <= 1'b0;
            resend_req   <= 1'b0;
        end else begin
            resend_req <= blk_ack || blk_nak;
            if (blk_deselect) begin
                chain_active <= 1'b0;
            end else if (rx_valid && rx_is_apdu && rx_last) begin
                chain_active <= blk_chain;
            end
        end
    end

    // ==================================================
    // APDU parser
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase      <= PH_CLA;
            cla        <= 8'h00;
            ins        <= 8'h00;
            p1         <= 8'h00;
            p2         <= 8'h00;
            lc         <= 8'h00;
            has_lc     <= 1'b0;
            dcount     <= 8'h00;
            wait_cnt   <= 20'h00000;
            sw_valid   <= 1'b0;
            sw1        <= 8'h00;
            sw2        <= 8'h00;
            acc_start  <= 1'b0;
            acc_write  <= 1'b0;
            acc_tunnel <= 1'b0;
            acc_addr   <= {AW{1'b0}};
            acc_len    <= 8'h00;
        end else begin
            sw_valid  <= 1'b0;
            acc_start <= 1'b0;
            case (phase)
                PH_CLA: begin
                    if (rx_valid && rx_is_apdu && link_state == ST_ACTIVE) begin
                        cla    <= rx_data;
                        lc     <= 8'h00;
                        has_lc <= 1'b0;
                        phase  <= rx_last ? PH_CLA : PH_INS;
                    end
                end
                PH_INS: begin
                    if (rx_valid) begin
                        ins   <= rx_data;
                        phase <= rx_last ? PH_CLA : PH_P1;
                    end
                end
                PH_P1: begin
                    if (rx_valid) begin
                        p1    <= rx_data;
                        phase <= rx_last ? PH_CLA : PH_P2;
                    end
                end
                PH_P2: begin
                    if (rx_valid) begin
                        p2    <= rx_data;
                        phase <= rx_last ? PH_WAIT : PH_LC;
                    end
                end
                PH_LC: begin
                    if (rx_valid) begin
                        lc     <= rx_data;
                        has_lc <= 1'b1;
                        dcount <= 8'h00;
                        phase  <= (rx_last || !is_wr) ? PH_WAIT : PH_DATA;
                    end
                end
                PH_DATA: begin
                    if (data_byte) begin
                        dcount <= dcount + 8'h01;
                        if (rx_last) begin
                            phase <= PH_WAIT;
                            if (dcount + 8'h01 != lc) begin
                                lc <= 8'hFF;
                            end
                        end
                    end
                end
                PH_WAIT: begin
                    // Header complete: decide status or forward
                    if (next_sw != `TBD_SW_OK || ins == `TBD_INS_SELECT) begin
                        sw_valid <= 1'b1;
                        sw1      <= next_sw[15:8];
                        sw2      <= next_sw[7:0];
                        phase    <= PH_CLA;
                    end else begin
                        acc_start  <= 1'b1;
                        acc_write  <= is_wr;
                        acc_tunnel <= tunnel;
                        acc_addr   <= addr_full[AW-1:0];
                        acc_len    <= lc;
                        wait_cnt   <= HOST_WAIT[19:0];
                        phase      <= PH_SKIP;
                    end
                end
                PH_SKIP: begin
                    if (!acc_tunnel || host_done) begin
                        sw_valid <= 1'b1;
                        // Memory access never reports a stale host error
                        if (acc_tunnel && host_err) begin
                            sw1 <= SW_HOSTER[15:8];
                        end else begin
                            sw1 <= SW_OK[15:8];
                        end
                        sw2      <= SW_OK[7:0];
                        phase    <= PH_CLA;
                    end else if (wait_cnt == 20'h00000) begin
                        sw_valid <= 1'b1;
                        sw1      <= SW_NOHOST[15:8];
                        sw2      <= 8'h00;
                        phase    <= PH_CLA;
                    end else begin
                        wait_cnt <= wait_cnt - 20'h00001;
                    end
                end
                default: begin
                    phase <= PH_CLA;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### tbd_map.vh
// Purpose: constants for the Type B command decoder
// Assumes: byte stream of frames, one byte per cycle
// Notes:   status words, codes, field positions
`ifndef TBD_MAP_VH
`define TBD_MAP_VH
// ==================================================
// Link-level command codes
`define TBD_CMD_REQ       8'h05
`define TBD_CMD_ATTACH    8'h1D
`define TBD_CMD_HALT      8'h50
`define TBD_PARAM_WAKE    3
// ==================================================
// Instruction codes
`define TBD_CLA_OK        8'h00
`define TBD_INS_SELECT    8'hA4
`define TBD_INS_READ      8'hB0
`define TBD_INS_WRITE     8'hD6
// ==================================================
// Address field positions
`define TBD_P1_TOP        7
`define TBD_MODE_HI       6
`define TBD_MODE_LO       4
`define TBD_MODE_RF       3'h0
`define TBD_MODE_TUNNEL   3'h4
// ==================================================
// Status words
`define TBD_SW_OK         16'h9000
`define TBD_SW_NOHOST     16'h5000
`define TBD_SW_HOSTERR    16'h5100
`define TBD_SW_LEN        16'h6700
`define TBD_SW_P1P2       16'h6A86
`define TBD_SW_INS        16'h6D00
`define TBD_SW_CLA        16'h6E00
`define TBD_SW_RO         16'h6F00
// ==================================================
// Timing
`define TBD_HOST_WAIT_US  100
`define TBD_CLK_MHZ       200
`endif

// ### tbd_fifo.v
// Purpose: small FIFO for payload bytes
// Assumes: single clock, asynchronous reset
// Notes:   data out from a register
`default_nettype none
module tbd_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    input  wire             flush,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    reg             have;
    wire            push;
    wire            pop;
    wire            load;
    // ==================================================
    // Storage plus one output register
    assign in_ready  = (count != DEPTH[AW:0]);
    assign push      = in_valid && in_ready;
    assign out_valid = have;
    assign load      = (count != {(AW+1){1'b0}}) && (!have || out_ready);
    assign pop       = load;
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr   <= {AW{1'b0}};
            rd_ptr   <= {AW{1'b0}};
            count    <= {(AW+1){1'b0}};
            have     <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
            have   <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr   <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
                out_data <= mem[rd_ptr];
            end
            if (push && !pop) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
            if (load) begin
                have <= 1'b1;
            end else if (out_ready) begin
                have <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### tbd_monitor.sv
// Purpose: port checker for tbd_decoder
// Assumes: bound to every tbd_decoder instance
// Notes:   host wait tracked in helper logic
`default_nettype none
module tbd_monitor #(
    parameter AW        = 15,
    parameter MAX_LEN   = 8'hF0,
    parameter HOST_WAIT = 20
) (
    // Clock, reset, inputs
    input wire logic          clk_sys,
    input wire logic          rst,
    input wire logic          blk_ack,
    input wire logic          blk_nak,
    input wire logic          blk_deselect,
    input wire logic [15:0]   read_only_region_setting,
    input wire logic          host_done,
    input wire logic          host_err,
    // Outputs watched
    input wire logic          sw_valid,
    input wire logic [7:0]    sw1,
    input wire logic [7:0]    sw2,
    input wire logic [2:0]    link_state,
    input wire logic          resend_req,
    input wire logic          acc_start,
    input wire logic          acc_write,
    input wire logic          acc_tunnel,
    input wire logic [AW-1:0] acc_addr,
    input wire logic [7:0]    acc_len
);
    logic [15:0] wait_cnt;
    logic        wait_on;
    logic        seen;
    logic        seen_err;
    // ====
    // Tunnel wait tracking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {wait_cnt, wait_on, seen, seen_err} <= '0;
        end else if (acc_start && acc_tunnel) begin
            {wait_cnt, wait_on, seen, seen_err} <= 19'h4;
        end else if (sw_valid) begin
            wait_on <= 1'b0;
        end else if (wait_on) begin
            wait_cnt <= wait_cnt + 16'h1;
            seen     <= seen | host_done;
            seen_err <= seen_err | (host_done & host_err);
        end
    end
    // ====
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_rf_start;
        acc_start && !acc_tunnel;
    endsequence
    sequence s_ok_answer;
        sw_valid && {sw1, sw2} == 16'h9000;
    endsequence
    sequence s_tunnel_end;
        sw_valid && wait_on;
    endsequence
    a_sw_single: assert property (sw_valid |=> !sw_valid)
        else $error("status valid longer than one cycle");
    a_sw_hold: assert property (!sw_valid |-> $stable({sw1, sw2}))
        else $error("status word changed without valid");
    a_rf_answer: assert property (s_rf_start |=> s_ok_answer)
        else $error("memory access not answered with normal end");
    a_mode_addr: assert property (acc_start |->
        acc_addr[AW-1:AW-3] == (acc_tunnel ? 3'h4 : 3'h0))
        else $error("access mode does not match address");
    a_len_range: assert property (acc_start |->
        acc_len <= MAX_LEN && (!acc_write || acc_len != 8'h00))
        else $error("access with length out of range");
    a_ro_guard: assert property ((s_rf_start and acc_write) |->
        {1'b0, acc_addr} >= read_only_region_setting)
        else $error("write into read-only region");
    a_active_only: assert property (acc_start |-> link_state == 3'h2)
        else $error("access outside active state");
    a_host_silent: assert property ((s_tunnel_end and !seen) |->
        {sw1, sw2} == 16'h5000 && wait_cnt >= HOST_WAIT - 2)
        else $error("silent host status wrong");
    a_wait_bound: assert property (wait_on |-> wait_cnt <= HOST_WAIT + 4)
        else $error("host wait too long");
    a_host_err: assert property ((s_tunnel_end and seen_err) |-> {sw1, sw2} == 16'h5100)
        else $error("host error status wrong");
    a_host_ok: assert property ((s_tunnel_end and seen && !seen_err) |-> s_ok_answer)
        else $error("host success status wrong");
    a_resend_blk: assert property (blk_ack || blk_nak |-> ##[1:2] resend_req)
        else $error("no resend after ack or nak");
    a_deselect_halt: assert property (blk_deselect |-> ##[1:2] link_state == 3'h3)
        else $error("deselect did not halt");
endmodule
bind tbd_decoder tbd_monitor #(.AW(AW), .MAX_LEN(MAX_LEN), .HOST_WAIT(HOST_WAIT)) mon (
    .clk_sys, .rst, .blk_ack, .blk_nak, .blk_deselect, .read_only_region_setting,
    .host_done, .host_err, .sw_valid, .sw1, .sw2, .link_state, .resend_req, .acc_start,
    .acc_write, .acc_tunnel, .acc_addr, .acc_len
);
`default_nettype wire

// ### tbd_host_model.sv
// Purpose: host and payload sink beside tbd_decoder
// Assumes: tunnel requests answered after a short random delay
// Notes:   mode 0 good, 1 error, 2 silent
`default_nettype none
module tbd_host_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Decoder side
    input  wire logic       acc_start,
    input  wire logic       acc_tunnel,
    input  wire logic       sw_valid,
    input  wire logic       stall,
    input  wire logic [1:0] mode,
    output logic            host_done,
    output logic            host_err,
    output logic            pay_ready
);
    logic [2:0] dly;
    logic       busy;
    // ====
    // Answer logic
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {busy, dly, host_done, host_err, pay_ready} <= '0;
        end else begin
            // Random stalls keep the FIFO under pressure
            pay_ready <= !stall && $urandom_range(1, 0) == 1;
            if (acc_start && acc_tunnel) begin
                busy <= 1'b1;
                dly  <= 3'($urandom_range(6, 1));
            end else if (sw_valid) begin
                {busy, host_done, host_err} <= '0;
            end else if (busy && dly != 3'h0) begin
                dly <= dly - 3'h1;
            end else if (busy && mode != 2'h2) begin
                host_done <= 1'b1;
                host_err  <= mode == 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench for tbd_decoder
// Assumes: host model stands on the tunnel side
// Notes:   driver queues expectations, a watcher compares
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, rx_valid, rx_last, rx_is_apdu, rx_ready, stall;
    logic        blk_chain, blk_ack, blk_nak, blk_deselect, host_done, host_err;
    logic        sw_valid, chain_active, resend_req, acc_start, acc_write, acc_tunnel;
    logic        pay_valid, pay_ready, full_seen;
    logic [7:0]  rx_data, sw1, sw2, acc_len, pay_data;
    logic [2:0]  link_state;
    logic [14:0] acc_addr;
    logic [15:0] read_only_region_setting;
    logic [1:0]  mode;
    logic [15:0] sw_q[$];
    logic [24:0] acc_seen;
    logic [24:0] acc_q[$];
    logic [7:0]  pay_q[$];
    int          fail_count, checked, sw_seen, cycles;
    // ====
    // Design and host
    assign acc_seen = {acc_write, acc_tunnel, acc_addr, acc_len};
    tbd_decoder #(.HOST_WAIT(20), .MEM_BYTES(16'h0C00)) dut (
        .clk_sys, .rst, .rx_valid, .rx_data, .rx_last, .rx_is_apdu, .blk_chain, .blk_ack,
        .blk_nak, .blk_deselect, .read_only_region_setting, .sw_valid, .sw1, .sw2,
        .link_state, .chain_active, .resend_req, .acc_start, .acc_write, .acc_tunnel,
        .acc_addr, .acc_len, .pay_valid, .pay_ready, .pay_data, .rx_ready, .host_done,
        .host_err
    );
    tbd_host_model host (.clk_sys, .rst, .acc_start, .acc_tunnel, .sw_valid, .stall, .mode,
        .host_done, .host_err, .pay_ready);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ====
    // Checking
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize;
        end
    end
    always @(posedge clk_sys) begin
        if (sw_valid === 1'b1) begin
            sw_seen++;
            if (sw_q.size() == 0) check("unexpected status", 0, 1);
            else check("status word", {sw1, sw2}, sw_q.pop_front());
        end
        if (acc_start === 1'b1) begin
            if (acc_q.size() == 0) check("unexpected access", 0, 1);
            else check("access", acc_seen, acc_q.pop_front());
        end
        // Refused data may still pass the FIFO, so only queued bytes count
        if (pay_valid === 1'b1 && pay_ready === 1'b1 && pay_q.size() > 0)
            check("payload", pay_data, pay_q.pop_front());
    end
    // ====
    // Driver
    task automatic send(input logic apdu, input logic [7:0] b[$]);
        foreach (b[i]) begin
            rx_valid = 1'b1;
            rx_is_apdu = apdu;
            rx_data = b[i];
            rx_last = (i == b.size() - 1);
            @(posedge clk_sys);
            while (!rx_ready) begin
                full_seen = 1'b1;
                @(posedge clk_sys);
            end
            @(negedge clk_sys);
        end
        rx_valid = 1'b0;
        rx_last = 1'b0;
    endtask
    task automatic link(input logic [7:0] b[$], input logic [2:0] st);
        send(1'b0, b);
        repeat (3) @(negedge clk_sys);
        check("link state", link_state, st);
    endtask
    task automatic apdu(input logic [7:0] b[$], input logic [15:0] sw);
        int t;
        t = sw_seen + 1;
        sw_q.push_back(sw);
        send(1'b1, b);
        // Let queued payload drain: the next frame start flushes the FIFO
        repeat (200) if (sw_seen < t || pay_q.size() > 0) @(negedge clk_sys);
        check("status count", sw_seen, t);
    endtask
    task automatic pulse(input int which);
        {blk_chain, blk_ack, blk_nak, blk_deselect} = 4'h8 >> which;
        @(negedge clk_sys);
        {blk_chain, blk_ack, blk_nak, blk_deselect} = 4'h0;
        repeat (3) @(negedge clk_sys);
    endtask
    initial begin
        logic [7:0] q[$];
        logic [7:0] p1, p2, d;
        int         k;
        logic [15:0] w;
        {rx_valid, rx_last, rx_is_apdu, rx_data, stall, mode} = '0;
        {blk_chain, blk_ack, blk_nak, blk_deselect} = 4'h0;
        read_only_region_setting = 16'h0100;
        rst = 1'b1;
        void'($urandom(32'h6455));
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        send(1'b1, '{8'h00, 8'hA4, 8'h00, 8'h00});
        repeat (10) @(negedge clk_sys);
        link('{8'h05, 8'h00, 8'h00}, 3'h1);
        link('{8'h1D}, 3'h2);
        link('{8'h50}, 3'h3);
        link('{8'h05, 8'h00, 8'h00}, 3'h3);
        link('{8'h05, 8'h00, 8'h08}, 3'h1);
        link('{8'h1D}, 3'h2);
        apdu('{8'h00, 8'hA4, 8'h00, 8'h00}, 16'h9000);
        apdu('{8'h01 + 8'($urandom % 255), 8'hB0, 8'h00, 8'h00, 8'h01}, 16'h6E00);
        apdu('{8'h00, 8'h10 + 8'($urandom % 128), 8'h00, 8'h00}, 16'h6D00);
        apdu('{8'h00, 8'hB0, 8'h80, 8'h00, 8'h01}, 16'h6A86);
        for (k = 1; k < 8; k++)
            if (k != 4) apdu('{8'h00, 8'hB0, {1'b0, 3'(k), 4'h0}, 8'h00, 8'h01}, 16'h6A86);
        p1 = {5'h00, 3'($urandom)};
        p2 = 8'($urandom);
        acc_q.push_back({2'b00, p1[6:0], p2, 8'h04});
        apdu('{8'h00, 8'hB0, p1, p2, 8'h04}, 16'h9000);
        apdu('{8'h00, 8'hB0, 8'h00, 8'h00, 8'hF1}, 16'h6700);
        apdu('{8'h00, 8'hB0, 8'h0B, 8'hFE, 8'h04}, 16'h6A86);
        apdu('{8'h00, 8'hD6, 8'h01, 8'h00}, 16'h6700);
        apdu('{8'h00, 8'hD6, 8'h01, 8'h00, 8'h00}, 16'h6700);
        // Long write against a stalled sink fills the FIFO
        q = '{8'h00, 8'hD6, 8'h02, 8'h00, 8'h0C};
        for (k = 0; k < 12; k++) begin
            d = 8'($urandom);
            q.push_back(d);
            pay_q.push_back(d);
        end
        acc_q.push_back({2'b10, 15'h0200, 8'h0C});
        stall = 1'b1;
        full_seen = 1'b0;
        fork
            begin
                repeat (40) @(negedge clk_sys);
                stall = 1'b0;
            end
        join_none
        apdu(q, 16'h9000);
        check("fifo refused", full_seen, 1);
        for (k = 0; k < 3; k++) begin
            mode = 2'(k);
            acc_q.push_back({2'b01, 7'h40, p2, 8'h02});
            w = (k == 0) ? 16'h9000 : ((k == 1) ? 16'h5100 : 16'h5000);
            apdu('{8'h00, 8'hB0, 8'h40, p2, 8'h02}, w);
        end
        mode = 2'h0;
        acc_q.push_back({2'b11, 15'h4030, 8'h01});
        pay_q.push_back(8'h3C);
        apdu('{8'h00, 8'hD6, 8'h40, 8'h30, 8'h01, 8'h3C}, 16'h9000);
        blk_chain = 1'b1;
        apdu('{8'h00, 8'hD6, 8'h00, 8'h20, 8'h02, 8'hAA, 8'h55}, 16'h6F00);
        blk_chain = 1'b0;
        check("chain flag", chain_active, 1);
        for (k = 0; k < 4; k++) pulse(k);
        check("deselect state", link_state, 3'h3);
        check("chain cleared", chain_active, 0);
        send(1'b1, '{8'h00, 8'hA4, 8'h00, 8'h00});
        repeat (20) @(negedge clk_sys);
        check("payload left", pay_q.size(), 0);
        check("access left", acc_q.size(), 0);
        check("status left", sw_q.size(), 0);
        summarize;
    end
endmodule
`default_nettype wire
